// >>> gpio_port_with_audio_selector.sv
// Four-pin general-purpose port with capture, output latch and audio selector.
// Assumes host-interface strobes are on ref_clk; pins and strap are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module gpio_port_with_audio_selector #(
    parameter int PINS = 4
) (
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // Decoded host writes
    input  wire logic            wr_stb,
    input  wire logic [3:0]      wr_cmd,
    input  wire logic [7:0]      wr_data,
    // Decoded host reads
    input  wire logic            rd_sel_stb,
    input  wire logic            rd_done_stb,
    input  wire logic [7:0]      rd_addr,
    output logic      [PINS-1:0] pin_input_capture,
    output logic                 pin_change_source_flag,
    // General-purpose pins
    input  wire logic [PINS-1:0] gpio_in,
    output logic      [PINS-1:0] gpio_out,
    output logic      [PINS-1:0] gpio_oe_n,
    // Interrupt pin, open drain, also the direction strap
    input  wire logic            int_pin_in,
    output logic                 int_pin_out,
    output logic                 int_pin_oe_n,
    // Receiver sources
    input  wire logic            pll_locked,
    input  wire logic            rx_clock_source_select,
    input  wire logic            pll_mck,
    input  wire logic            pll_bck,
    input  wire logic            pll_lrck,
    input  wire logic            pll_data,
    input  wire logic            xin_mck,
    input  wire logic            xin_bck,
    input  wire logic            xin_lrck,
    input  wire logic            aux_serial_data_in,
    // Selector outputs
    output logic                 rx_master_clock_out,
    output logic                 rx_bit_clock_out,
    output logic                 rx_word_clock_out,
    output logic                 rx_data_out
);

    // Pin synchronisers: three stages, second and third must agree
    logic [PINS-1:0] pin_s1_r, pin_s2_r, pin_s3_r;
    logic [PINS-1:0] pin_val_r, pin_val_nxt;
    logic [2:0]      strap_sync_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_s1_r     <= '0;
            pin_s2_r     <= '0;
            pin_s3_r     <= '0;
            strap_sync_r <= 3'h0;
        end else begin
            pin_s1_r     <= gpio_in;
            pin_s2_r     <= pin_s1_r;
            pin_s3_r     <= pin_s2_r;
            strap_sync_r <= {strap_sync_r[1:0], int_pin_in};
        end
    end

    // Per-bit filter: a change counts only once two stages agree
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_filt
            assign pin_val_nxt[gi] = (pin_s2_r[gi] == pin_s3_r[gi]) ? pin_s3_r[gi] : pin_val_r[gi];
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) pin_val_r <= '0;
        else     pin_val_r <= pin_val_nxt;
    end

    // Direction strap, caught once after reset release; waits until the
    // synchroniser holds real pin samples, else its reset zeros would win
    gpio_sel_pkg::strap_state_t strap_st_r, strap_st_nxt;
    logic       dir_out_r, dir_out_nxt;
    logic [1:0] strap_fill_r, strap_fill_nxt;

    always_comb begin
        strap_st_nxt   = strap_st_r;
        dir_out_nxt    = dir_out_r;
        strap_fill_nxt = strap_fill_r + {1'b0, !(&strap_fill_r)}; // Saturates
        case (strap_st_r)
            gpio_sel_pkg::STRAP_WAIT: begin
                if ((&strap_fill_r) && strap_sync_r[1] == strap_sync_r[2]) begin
                    dir_out_nxt  = strap_sync_r[2];
                    strap_st_nxt = gpio_sel_pkg::STRAP_DONE;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_st_r   <= gpio_sel_pkg::STRAP_WAIT;
            dir_out_r    <= 1'b0;
            strap_fill_r <= 2'h0;
        end else begin
            strap_st_r   <= strap_st_nxt;
            dir_out_r    <= dir_out_nxt;
            strap_fill_r <= strap_fill_nxt;
        end
    end

    logic dir_in;
    assign dir_in = (strap_st_r == gpio_sel_pkg::STRAP_DONE) && !dir_out_r;

    // Host-written controls
    logic [PINS-1:0]         latch_r, latch_nxt;
    gpio_sel_pkg::sel_ctrl_t ctrl_r, ctrl_nxt;
    logic                    irq_en_r, irq_en_nxt;
    logic                    output_clock_source_select_r, output_clock_source_select_nxt;

    always_comb begin
        latch_nxt  = latch_r;
        ctrl_nxt   = ctrl_r;
        irq_en_nxt = irq_en_r;
        output_clock_source_select_nxt = output_clock_source_select_r;
        if (wr_stb) begin
            if (wr_cmd == gpio_sel_pkg::CMD_PIN_OUTPUT) begin
                latch_nxt = wr_data[gpio_sel_pkg::POS_LATCH_LSB +: PINS];
            end else if (wr_cmd == gpio_sel_pkg::CMD_DATA_IO2) begin
                ctrl_nxt.fsel    = wr_data[gpio_sel_pkg::POS_FUNC_SEL];
                ctrl_nxt.external_source_select  = wr_data[gpio_sel_pkg::POS_EXT_SEL];
                ctrl_nxt.mck_inv = wr_data[gpio_sel_pkg::POS_MCLK_INV];
                ctrl_nxt.dmute   = wr_data[gpio_sel_pkg::POS_DATA_MUTE];
            end else if (wr_cmd == gpio_sel_pkg::CMD_INT_SELECT) begin
                irq_en_nxt = wr_data[gpio_sel_pkg::POS_INT_PIN_CHANGE];
            end else if (wr_cmd == gpio_sel_pkg::CMD_SOURCE_SW) begin
                output_clock_source_select_nxt = wr_data[gpio_sel_pkg::POS_OUT_CLK_SEL];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            latch_r  <= gpio_sel_pkg::RST_PIN_LATCH;
            ctrl_r   <= '0;
            irq_en_r <= 1'b0;
            output_clock_source_select_r <= 1'b0;
        end else begin
            latch_r  <= latch_nxt;
            ctrl_r   <= ctrl_nxt;
            irq_en_r <= irq_en_nxt;
            output_clock_source_select_r <= output_clock_source_select_nxt;
        end
    end

    // Output mode: latch drives pins, enable low while driving
    assign gpio_out  = latch_r;
    assign gpio_oe_n = {PINS{!(dir_out_r && strap_st_r == gpio_sel_pkg::STRAP_DONE)}};

    // 24 kHz sample tick; relies on the crystal running without pause
    logic [gpio_sel_pkg::SAMPLE_CW-1:0] tick_cnt_r, tick_cnt_nxt;
    logic                               tick;

    assign tick = (tick_cnt_r == gpio_sel_pkg::SAMPLE_CW'(gpio_sel_pkg::SAMPLE_CYCLES - 1));

    always_comb begin
        tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) tick_cnt_r <= '0;
        else     tick_cnt_r <= tick_cnt_nxt;
    end

    // Capture register and pin-change interrupt
    logic            cap_mode;
    logic            rd_ea, rd_eb_sel, rd_eb_done, change_evt;
    logic [PINS-1:0] cap_r, cap_nxt, ref_r, ref_nxt;
    logic            int_r, int_nxt, flag_r, flag_nxt;

    assign cap_mode   = dir_in && !ctrl_r.fsel;
    assign rd_ea      = rd_sel_stb && (rd_addr == gpio_sel_pkg::RD_ADDR_INT_SRC);
    assign rd_eb_sel  = rd_sel_stb && (rd_addr == gpio_sel_pkg::RD_ADDR_CAPTURE);
    assign rd_eb_done = rd_done_stb && (rd_addr == gpio_sel_pkg::RD_ADDR_CAPTURE);
    // No transfer while the interrupt is pending
    assign change_evt = cap_mode && irq_en_r && tick && !int_r && (pin_val_r != ref_r);

    always_comb begin
        cap_nxt  = cap_r;
        ref_nxt  = ref_r;
        int_nxt  = int_r;
        flag_nxt = flag_r;
        if (rd_ea) begin
            int_nxt  = 1'b0;
            flag_nxt = 1'b0;
        end
        // A new change wins over a same-cycle readout clear
        if (change_evt) begin
            cap_nxt = pin_val_r;
        end else if (rd_eb_done && cap_mode) begin
            cap_nxt = gpio_sel_pkg::RST_CAPTURE;
        end else if (rd_eb_sel && cap_mode && !irq_en_r) begin
            cap_nxt = pin_val_r;
        end
        // Set wins over a same-cycle clear
        if (change_evt) begin
            ref_nxt  = pin_val_r;
            int_nxt  = 1'b1;
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cap_r  <= gpio_sel_pkg::RST_CAPTURE;
            ref_r  <= '0;
            int_r  <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            cap_r  <= cap_nxt;
            ref_r  <= ref_nxt;
            int_r  <= int_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign pin_input_capture      = cap_r;
    assign pin_change_source_flag = flag_r;
    // Open drain: only ever pulls low
    assign int_pin_out  = 1'b0;
    assign int_pin_oe_n = !int_r;

    // Selector: a clock mux, so it stays combinational on the pins
    logic ext_active, use_pll;
    assign ext_active = dir_in && ctrl_r.fsel && ctrl_r.external_source_select;
    assign use_pll    = pll_locked && !output_clock_source_select_r && !rx_clock_source_select;

    always_comb begin
        if (ext_active) begin
            rx_master_clock_out = gpio_in[0] ^ ctrl_r.mck_inv;
            rx_bit_clock_out    = gpio_in[1];
            rx_word_clock_out   = gpio_in[2];
            rx_data_out         = ctrl_r.dmute ? gpio_sel_pkg::MUTE_LEVEL : gpio_in[3];
        end else if (use_pll) begin
            rx_master_clock_out = pll_mck;
            rx_bit_clock_out    = pll_bck;
            rx_word_clock_out   = pll_lrck;
            rx_data_out         = pll_data;
        end else begin
            rx_master_clock_out = xin_mck;
            rx_bit_clock_out    = xin_bck;
            rx_word_clock_out   = xin_lrck;
            rx_data_out         = aux_serial_data_in;
        end
    end

    // Checks
    property p_out_drive;
        @(posedge ref_clk) disable iff (rst)
        (strap_st_r == gpio_sel_pkg::STRAP_DONE && dir_out_r) |-> (gpio_oe_n == '0 && gpio_out == latch_r);
    endproperty
    a_out_drive: assert property (p_out_drive) else $error("pins not driven from latch");

    property p_latch_wr;
        @(posedge ref_clk) disable iff (rst)
        (wr_stb && wr_cmd == gpio_sel_pkg::CMD_PIN_OUTPUT) |=> (gpio_out == $past(wr_data[7:4]));
    endproperty
    a_latch_wr: assert property (p_latch_wr) else $error("latch write lost");

    property p_int_set;
        @(posedge ref_clk) disable iff (rst)
        change_evt |=> (!int_pin_oe_n && pin_change_source_flag && pin_input_capture == $past(pin_val_r));
    endproperty
    a_int_set: assert property (p_int_set) else $error("pin change did not raise interrupt");

    property p_int_hold;
        @(posedge ref_clk) disable iff (rst)
        (int_r && !rd_ea && !rd_done_stb) |=> ($stable(pin_input_capture) && !int_pin_oe_n);
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("capture moved while pending");

    property p_int_clr;
        @(posedge ref_clk) disable iff (rst)
        (rd_ea && !change_evt) |=> int_pin_oe_n;
    endproperty
    a_int_clr: assert property (p_int_clr) else $error("interrupt not released");

    property p_clear_read;
        @(posedge ref_clk) disable iff (rst)
        (rd_eb_done && cap_mode && !change_evt) |=> (pin_input_capture == gpio_sel_pkg::RST_CAPTURE);
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("capture not cleared");

    property p_sel_capture;
        @(posedge ref_clk) disable iff (rst)
        (rd_eb_sel && cap_mode && !irq_en_r && !rd_done_stb) |=> (pin_input_capture == $past(pin_val_r));
    endproperty
    a_sel_capture: assert property (p_sel_capture) else $error("select did not capture");

    property p_ext_route;
        @(posedge ref_clk) disable iff (rst)
        ext_active |-> (rx_master_clock_out == (gpio_in[0] ^ ctrl_r.mck_inv) && rx_word_clock_out == gpio_in[2]);
    endproperty
    a_ext_route: assert property (p_ext_route) else $error("external route wrong");

    property p_mute;
        @(posedge ref_clk) disable iff (rst)
        (ext_active && ctrl_r.dmute) |-> (rx_data_out == gpio_sel_pkg::MUTE_LEVEL);
    endproperty
    a_mute: assert property (p_mute) else $error("external data not muted");

    property p_no_ext_capture;
        @(posedge ref_clk) disable iff (rst)
        (!ctrl_r.fsel && !use_pll) |-> (rx_master_clock_out == xin_mck && rx_data_out == aux_serial_data_in);
    endproperty
    a_no_ext_capture: assert property (p_no_ext_capture) else $error("ext select leaked");

    property p_tick_gap;
        @(posedge ref_clk) disable iff (rst)
        tick |=> !tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("sample tick too fast");

    c_change:  cover property (@(posedge ref_clk) disable iff (rst) change_evt ##[1:50] rd_ea);
    c_resel:   cover property (@(posedge ref_clk) disable iff (rst) rd_ea ##[1:50] change_evt);
    c_ext:     cover property (@(posedge ref_clk) disable iff (rst) ext_active && ctrl_r.mck_inv);
    c_pollcap: cover property (@(posedge ref_clk) disable iff (rst) rd_eb_sel && cap_mode && !irq_en_r);

endmodule // gpio_port_with_audio_selector

`default_nettype wire

// >>> gpio_sel_pkg.sv
// Constants and carrier types for the four-pin general-purpose port.
// Assumes the serial host interface decodes frames and delivers strobes.
package gpio_sel_pkg;

    // Host-interface addresses
    localparam logic [7:0] RD_ADDR_INT_SRC  = 8'hea;
    localparam logic [7:0] RD_ADDR_CAPTURE  = 8'heb;
    localparam logic [3:0] CMD_INT_SELECT   = 4'h8;
    localparam logic [3:0] CMD_SOURCE_SW    = 4'h5;
    localparam logic [3:0] CMD_PIN_OUTPUT   = 4'ha;
    localparam logic [3:0] CMD_DATA_IO2     = 4'hd;

    // Field positions within the 8-bit data byte (DI8 is bit 0)
    localparam int POS_INT_PIN_CHANGE = 6;
    localparam int POS_OUT_CLK_SEL    = 1;
    localparam int POS_LATCH_LSB      = 4;
    localparam int POS_FUNC_SEL       = 0;
    localparam int POS_EXT_SEL        = 1;
    localparam int POS_MCLK_INV       = 2;
    localparam int POS_DATA_MUTE      = 3;
    localparam int POS_FLAG_IN_EA     = 6;

    // Reset values and mute level
    localparam logic [3:0] RST_PIN_LATCH = 4'h0;
    localparam logic [3:0] RST_CAPTURE   = 4'h0;
    localparam logic       MUTE_LEVEL    = 1'b0;

    // Timing: 24 kHz sampling derived from the 10 MHz reference
    localparam int CLK_HZ        = 10_000_000;
    localparam int SAMPLE_HZ     = 24_000;
    localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
    localparam int SAMPLE_CW     = 9;

    // Selector controls carried together
    typedef struct packed {
        logic dmute;
        logic mck_inv;
        logic external_source_select;
        logic fsel;
    } sel_ctrl_t;

    typedef enum logic [0:0] {
        STRAP_WAIT = 1'b0,
        STRAP_DONE = 1'b1
    } strap_state_t;

endpackage

// >>> gpio_far_side.sv
// Far-side model: peripheral ICs on the four pins and the strap resistor on the interrupt wire.
// Assumes the design drives a pin only while its output enable is low.
`timescale 1ns/1ps
`default_nettype none

module gpio_far_side (
    // Strap and peripheral levels
    input  wire logic       strap_up,
    input  wire logic [3:0] peer_drive,
    // Design pin side
    input  wire logic [3:0] gpio_out,
    input  wire logic [3:0] gpio_oe_n,
    input  wire logic       int_pin_out,
    input  wire logic       int_pin_oe_n,
    // Resolved wire levels
    output logic      [3:0] gpio_in,
    output logic            int_pin_in
);
    // Open-drain wire; the resistor gives idle level and direction strap
    assign int_pin_in = (!int_pin_oe_n && !int_pin_out) ? 1'b0 : strap_up;

    // Peripheral drives a pin only while the design has released it
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            gpio_in[i] = gpio_oe_n[i] ? peer_drive[i] : gpio_out[i];
        end
    end
endmodule // gpio_far_side

`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the four-pin port: capture, interrupt, selector, output latch.
// Assumes the design package and the far-side model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       wr_stb = 1'b0;
    logic [3:0] wr_cmd = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic       rd_sel_stb = 1'b0;
    logic       rd_done_stb = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic       pll_locked = 1'b1;
    logic       rcs = 1'b0;
    logic [3:0] pll_v = 4'hc;
    logic [3:0] xin_v = 4'h6;
    logic       strap_up = 1'b0;
    logic [3:0] peer = 4'h0;
    logic [3:0] cap, gpio_in, gpio_out, gpio_oe_n;
    logic       flag, int_in, int_out, int_oe_n, mck, bck, lrck, dout;
    int         err_total = 0;
    int         checks = 0;

    gpio_port_with_audio_selector uut (
        .ref_clk(ref_clk), .rst(rst), .wr_stb(wr_stb), .wr_cmd(wr_cmd), .wr_data(wr_data),
        .rd_sel_stb(rd_sel_stb), .rd_done_stb(rd_done_stb), .rd_addr(rd_addr),
        .pin_input_capture(cap), .pin_change_source_flag(flag),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .int_pin_in(int_in), .int_pin_out(int_out), .int_pin_oe_n(int_oe_n),
        .pll_locked(pll_locked), .rx_clock_source_select(rcs),
        .pll_mck(pll_v[0]), .pll_bck(pll_v[1]), .pll_lrck(pll_v[2]), .pll_data(pll_v[3]),
        .xin_mck(xin_v[0]), .xin_bck(xin_v[1]), .xin_lrck(xin_v[2]), .aux_serial_data_in(xin_v[3]),
        .rx_master_clock_out(mck), .rx_bit_clock_out(bck), .rx_word_clock_out(lrck), .rx_data_out(dout)
    );

    gpio_far_side far (
        .strap_up(strap_up), .peer_drive(peer), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .int_pin_out(int_out), .int_pin_oe_n(int_oe_n), .gpio_in(gpio_in), .int_pin_in(int_in)
    );

    // Crystal clock kept running throughout, interrupt sampling relies on it
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk4(input logic [3:0] got, input logic [3:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        chk4({3'h0, got}, {3'h0, exp}, what);
    endtask

    task automatic wr(input logic [3:0] cmd, input logic [7:0] d);
        @(negedge ref_clk);
        wr_stb = 1'b1;
        wr_cmd = cmd;
        wr_data = d;
        @(negedge ref_clk);
        wr_stb = 1'b0;
    endtask

    // Select when done is 0, end of shift-out when done is 1
    task automatic rd(input logic done, input logic [7:0] a);
        @(negedge ref_clk);
        rd_addr = a;
        rd_sel_stb = !done;
        rd_done_stb = done;
        @(negedge ref_clk);
        rd_sel_stb = 1'b0;
        rd_done_stb = 1'b0;
    endtask

    // Bounded wait: 1000 cycles, more than two sample periods plus filter latency
    task automatic wait_int();
        for (int i = 0; i < 1000 && int_oe_n !== 1'b0; i++) begin
            @(negedge ref_clk);
        end
        chk1(int_oe_n, 1'b0, "interrupt asserted");
    endtask

    task automatic do_reset(input logic up);
        strap_up = up;
        rst = 1'b1;
        repeat (20) @(negedge ref_clk);
        chk4(gpio_oe_n, 4'hf, "oe during reset");
        chk4(gpio_out, 4'h0, "latch during reset");
        chk4(cap, 4'h0, "capture during reset");
        rst = 1'b0;
        repeat (8) @(negedge ref_clk);
    endtask

    task automatic sel(input logic [3:0] exp, input string what);
        #1;
        chk4({dout, lrck, bck, mck}, exp, what);
    endtask

    task automatic test_end(input string name);
        $display("test %s done, %0d checks, %0d mismatches", name, checks, err_total);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        #2_000_000;
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        // Input strap, interrupt-driven capture
        do_reset(1'b0);
        chk4(gpio_oe_n, 4'hf, "input direction");
        chk1(int_oe_n, 1'b1, "interrupt idle");
        wr(gpio_sel_pkg::CMD_INT_SELECT, 8'h40);
        peer = 4'h6;
        wait_int();
        chk4(cap, 4'h6, "changed pins captured");
        chk1(flag, 1'b1, "source flag set");
        peer = 4'h3;
        repeat (900) @(negedge ref_clk);
        chk4(cap, 4'h6, "transfers stopped");
        rd(1'b0, gpio_sel_pkg::RD_ADDR_INT_SRC);
        chk1(int_oe_n, 1'b1, "interrupt released");
        chk1(flag, 1'b0, "flag cleared");
        chk4(cap, 4'h6, "capture held");
        wait_int();
        chk4(cap, 4'h3, "newer value captured");
        rd(1'b1, gpio_sel_pkg::RD_ADDR_CAPTURE);
        chk4(cap, 4'h0, "cleared after readout");
        rd(1'b0, gpio_sel_pkg::RD_ADDR_INT_SRC);
        wr(gpio_sel_pkg::CMD_INT_SELECT, 8'h00);
        test_end("interrupt capture");
        // Polled capture at address select
        peer = 4'h9;
        repeat (6) @(negedge ref_clk);
        rd(1'b0, gpio_sel_pkg::RD_ADDR_CAPTURE);
        chk4(cap, 4'h9, "polled capture");
        rd(1'b1, gpio_sel_pkg::RD_ADDR_CAPTURE);
        chk4(cap, 4'h0, "polled clear");
        test_end("polled capture");
        // Selector, set only while acting as clock master
        peer = 4'hb;
        repeat (6) @(negedge ref_clk);
        wr(gpio_sel_pkg::CMD_DATA_IO2, 8'h03);
        sel(4'hb, "external pins routed");
        wr(gpio_sel_pkg::CMD_DATA_IO2, 8'h0f);
        sel(4'h2, "invert and mute");
        wr(gpio_sel_pkg::CMD_DATA_IO2, 8'h0e);
        sel(4'hc, "capture mode ignores controls");
        @(negedge ref_clk);
        pll_locked = 1'b0;
        sel(4'h6, "unlocked crystal and aux");
        @(negedge ref_clk);
        pll_locked = 1'b1;
        rcs = 1'b1;
        sel(4'h6, "clock select forces crystal");
        @(negedge ref_clk);
        rcs = 1'b0;
        wr(gpio_sel_pkg::CMD_SOURCE_SW, 8'h02);
        sel(4'h6, "output select forces crystal");
        wr(gpio_sel_pkg::CMD_SOURCE_SW, 8'h00);
        sel(4'hc, "locked pll routed");
        test_end("selector");
        // Output strap, two latch writes then a write of another command, each strobe but the last followed by an idle cycle
        do_reset(1'b1);
        wr(gpio_sel_pkg::CMD_PIN_OUTPUT, 8'h50);
        chk4(gpio_out, 4'h5, "latch drives pins");
        chk4(gpio_oe_n, 4'h0, "output direction");
        wr(gpio_sel_pkg::CMD_PIN_OUTPUT, 8'ha0);
        wr(4'h3, 8'h50);
        chk4(gpio_in, 4'ha, "other command ignored");
        chk1(int_in, 1'b1, "strap idle high");
        test_end("output latch");
        give_verdict();
    end
endmodule // testbench

`default_nettype wire
